// >>> rtl/dvrs_defs.vh
`ifndef DVRS_DEFS_VH
`define DVRS_DEFS_VH

// Operative modes
`define DVRS_MODE_FINE 2'h0
`define DVRS_MODE_LEGACY 2'h1
`define DVRS_MODE_ALT 2'h2

// Stepping clock multiplier in fine mode
`define DVRS_FINE_MULT 2'h3

// Reference step sizes in microvolts
`define DVRS_STEP_FINE_UV 16'h30d4
`define DVRS_STEP_COARSE_UV 16'h61a8

// Supervision re-enable delay after a transition, clock cycles
`define DVRS_MASK_HOLD 6'h20

// On-time limit: fraction of period in 1/256 units at 0 and full scale
`define DVRS_TON_MAX_ZERO 8'hcd
`define DVRS_TON_MAX_FULL 8'h66
// Full-scale sense current in 1/10 uA
`define DVRS_SENSE_FULL 16'h015e

// Offset current in 1/10 uA
`define DVRS_OFFSET_CUR 8'h73

`endif

// >>> rtl/dvrs_step_clock.v
`timescale 1ns/100ps
`include "dvrs_defs.vh"

// Makes rise and fall enables of the stepping clock from the switching period
module dvrs_step_clock #(
   parameter PW = 16
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Control
   input wire [PW-1:0] sw_period,
   input wire fine,
   // Stepping clock edges
   output reg rise,
   output reg fall
);

   reg [PW-1:0] cnt;
   wire [PW-1:0] div;
   wire [PW-1:0] half;

   // Fine mode runs three times faster; coarse runs at switching rate
   assign div = fine ? (sw_period / `DVRS_FINE_MULT) : sw_period;
   assign half = {1'b0, div[PW-1:1]};

   // Divider producing one-cycle edge enables
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= {PW{1'b0}};
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         rise <= 1'b0;
         fall <= 1'b0;
         if (cnt + 1'b1 >= div || half == {PW{1'b0}}) begin
            cnt <= {PW{1'b0}};
            rise <= 1'b1;
         end else begin
            cnt <= cnt + 1'b1;
            if (cnt + 1'b1 == half)
               fall <= 1'b1;
         end
      end
   end

endmodule // dvrs_step_clock

// >>> rtl/dvrs_stepper.v
`timescale 1ns/100ps
`include "dvrs_defs.vh"
// Function
// - A changed code seen on a stepping-clock rise is accepted only if it is unchanged at the next fall.
// - From the next rise after confirmation the reference moves one step per stepping-clock cycle toward the code.
// - Code changes are ignored during a transition and watching resumes at the first rise after it ends.
// - In fine mode the stepping clock runs at three times the per-phase switching frequency.
// - In both coarse modes the stepping clock runs at the switching frequency.
// - The step is 12.5 mV in fine mode and 25 mV in the coarse modes.
// - Power-good, overvoltage and undervoltage supervision are masked during a transition and for 32 cycles after.
// - A jump of several steps is still walked one step per stepping-clock cycle.
// - Dynamic code changes work in every operative mode.
// - The on-time limit falls linearly from 0.80 of the period at zero sense current to 0.40 at 35 uA.
// - The 11.5 uA offset current turns on when soft-start begins and stays on while enabled.
module dvrs_stepper #(
   parameter CW = 8,
   parameter PW = 16
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Configuration
   input wire [1:0] mode,
   input wire [PW-1:0] sw_period,
   input wire enable,
   input wire soft_start_begin,
   // Processor code
   input wire [CW-1:0] vid_code,
   // Raw supervision
   input wire power_good_raw,
   input wire overvoltage_raw,
   input wire undervoltage_raw,
   // Current sense, 1/10 uA
   input wire [15:0] phase_sense_current,
   // Reference
   output reg [CW-1:0] reference_code,
   output reg [15:0] step_uv,
   output reg transition_busy,
   output reg transition_done,
   // Supervision
   output reg power_good_output,
   output reg overvoltage_trip,
   output reg undervoltage_trip,
   output reg supervision_masked,
   // On-time limit, period cycles
   output reg [PW-1:0] max_on_time,
   // Offset current source
   output reg offset_current_on,
   output reg [7:0] offset_current
);

   // Tracking states
   localparam ST_WATCH = 2'h0;
   localparam ST_CONFIRM = 2'h1;
   localparam ST_ARM = 2'h2;
   localparam ST_STEP = 2'h3;

   // Width of the period times an 8-bit fraction
   localparam PRW = PW + 8;

   // Tracking registers and their next values
   reg [1:0] state;
   reg [1:0] next_state;
   reg [CW-1:0] sampled;
   reg [CW-1:0] next_sampled;
   reg [CW-1:0] target;
   reg [CW-1:0] next_target;
   reg [CW-1:0] next_reference;
   reg next_busy;
   reg next_done;

   // Stepping clock edges and mode decode
   wire rise;
   wire fall;
   wire fine;

   // Step direction and the tests the tracker makes
   wire step_up;
   wire [CW-1:0] step_code;
   wire last_step;
   wire code_moved;
   wire code_held;
   wire confirm;

   // Supervision mask timing
   reg [5:0] hold_cnt;
   reg [5:0] next_hold_cnt;
   reg next_masked;
   wire mask_now;

   // On-time limit arithmetic
   wire [7:0] ton_span;
   reg [15:0] span_prod;
   reg [15:0] span_quot;
   reg [7:0] frac;
   reg [PRW-1:0] prod;

   // Fine mode steps three times per switching period, both coarse modes once
   assign fine = (mode == `DVRS_MODE_FINE);

   // Edge enables of the stepping clock
   // A mode change alters the division at once, so the first period after it may be short or long
   dvrs_step_clock #(
      .PW(PW)
   ) u_clk (
      .clk(clk),
      .nrst(nrst),
      .sw_period(sw_period),
      .fine(fine),
      .rise(rise),
      .fall(fall)
   );

   // Direction and size of the next step; the reference never overshoots or wraps
   assign step_up = (target > reference_code);
   assign step_code = step_up ? reference_code + 1'b1 : reference_code - 1'b1;
   assign last_step = (step_code == target);

   // Code watching; a change is only a candidate until the fall confirms it
   // Confirm is also fed to the mask so supervision closes on the same edge as busy rises
   assign code_moved = (vid_code != reference_code);
   assign code_held = (vid_code == sampled);
   assign confirm = (state == ST_CONFIRM) && fall && code_held;

   // Tracker walk: a rise that sees a new code records it, the fall half a
   // stepping period later confirms it, and every following rise moves the
   // reference one step. The code lines are deaf from confirmation until the
   // done pulse, so a processor that changes the code faster than two stepping
   // periods loses the later change until the walk ends.

   // Next state of the tracker; same path in every mode
   always @* begin
      next_state = state;
      next_sampled = sampled;
      next_target = target;
      next_reference = reference_code;
      next_busy = transition_busy;
      next_done = 1'b0;
      case (state)
         ST_WATCH: begin
            // Only codes that differ from the reference start a check
            if (rise && code_moved) begin
               next_sampled = vid_code;
               next_state = ST_CONFIRM;
            end
         end
         ST_CONFIRM: begin
            // Codes that moved again by the fall are dropped as glitches
            if (fall) begin
               if (code_held) begin
                  next_target = sampled;
                  next_busy = 1'b1;
                  next_state = ST_ARM;
               end else begin
                  next_state = ST_WATCH;
               end
            end
         end
         ST_ARM: begin
            // First step on the rise after the confirming fall
            if (rise) begin
               next_reference = step_code;
               next_state = ST_STEP;
               if (last_step) begin
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  next_state = ST_WATCH;
               end
            end
         end
         ST_STEP: begin
            // Code lines are not looked at until the target is reached
            if (rise) begin
               next_reference = step_code;
               if (last_step) begin
                  next_busy = 1'b0;
                  next_done = 1'b1;
                  next_state = ST_WATCH;
               end
            end
         end
         default: begin
            next_state = ST_WATCH;
         end
      endcase
   end

   // Tracking registers; done is a one-cycle pulse as its next value defaults low
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_WATCH;
         sampled <= {CW{1'b0}};
         target <= {CW{1'b0}};
         reference_code <= {CW{1'b0}};
         transition_busy <= 1'b0;
         transition_done <= 1'b0;
      end else begin
         state <= next_state;
         sampled <= next_sampled;
         target <= next_target;
         reference_code <= next_reference;
         transition_busy <= next_busy;
         transition_done <= next_done;
      end
   end

   // Step size follows the mode; reset value matches the reset mode decode
   // Mode 3 falls in with the coarse modes
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         step_uv <= `DVRS_STEP_FINE_UV;
      else
         step_uv <= fine ? `DVRS_STEP_FINE_UV : `DVRS_STEP_COARSE_UV;
   end

   // Mask from the confirming fall; the hold count restarts at every done pulse
   // Counted on the system clock, so the delay does not stretch with a slow switching rate
   always @* begin
      next_hold_cnt = hold_cnt;
      next_masked = supervision_masked;
      if (confirm || transition_busy) begin
         next_hold_cnt = 6'h00;
         next_masked = 1'b1;
      end else if (transition_done) begin
         next_hold_cnt = 6'h01;
         next_masked = 1'b1;
      end else if (hold_cnt != 6'h00) begin
         if (hold_cnt == `DVRS_MASK_HOLD) begin
            next_hold_cnt = 6'h00;
            next_masked = 1'b0;
         end else begin
            next_hold_cnt = hold_cnt + 6'h01;
         end
      end
   end

   // Mask registers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_cnt <= 6'h00;
         supervision_masked <= 1'b0;
      end else begin
         hold_cnt <= next_hold_cnt;
         supervision_masked <= next_masked;
      end
   end

   // Gate also covers the confirming cycle so no trip slips out before the mask register sets
   assign mask_now = confirm | transition_busy | supervision_masked;

   // Gated supervision; power good holds its last value while masked
   // Holding rather than forcing high keeps an already bad supply from reporting good
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_good_output <= 1'b0;
         overvoltage_trip <= 1'b0;
         undervoltage_trip <= 1'b0;
      end else begin
         power_good_output <= mask_now ? power_good_output : power_good_raw;
         overvoltage_trip <= overvoltage_raw & ~mask_now;
         undervoltage_trip <= undervoltage_raw & ~mask_now;
      end
   end

   // Span between the limits at zero and at full-scale current
   assign ton_span = `DVRS_TON_MAX_ZERO - `DVRS_TON_MAX_FULL;

   // Linear on-time fraction in 1/256 units, saturating above full-scale current
   // The span product fits 16 bits because the current is under full scale on that path
   always @* begin
      span_prod = {8'h00, ton_span} * phase_sense_current;
      span_quot = span_prod / `DVRS_SENSE_FULL;
      if (phase_sense_current >= `DVRS_SENSE_FULL)
         frac = `DVRS_TON_MAX_FULL;
      else
         frac = `DVRS_TON_MAX_ZERO - span_quot[7:0];
      prod = {8'h00, sw_period} * {{PW{1'b0}}, frac};
   end

   // Limit in clock cycles of the switching period
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         max_on_time <= {PW{1'b0}};
      else
         max_on_time <= prod[PRW-1:8];
   end

   // Offset source: on from soft-start, off when disabled; disable wins if both come together
   // The source is a level, so a repeated soft-start strobe while on changes nothing
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         offset_current_on <= 1'b0;
         offset_current <= 8'h00;
      end else if (!enable) begin
         offset_current_on <= 1'b0;
         offset_current <= 8'h00;
      end else if (soft_start_begin) begin
         offset_current_on <= 1'b1;
         offset_current <= `DVRS_OFFSET_CUR;
      end
   end

endmodule // dvrs_stepper

// >>> dv/dvrs_props.sv
`timescale 1ns/100ps
// Stepping, masking and step size seen at the stepper ports
module dvrs_props (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Watched ports
   input wire [1:0] mode,
   input wire [7:0] reference_code,
   input wire [15:0] step_uv,
   input wire transition_busy,
   input wire transition_done,
   input wire power_good_output,
   input wire overvoltage_trip,
   input wire undervoltage_trip,
   input wire supervision_masked
);
   reg [5:0] since;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Cycles since done, saturating so long idle stays quiet
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         since <= 6'h3f;
      else if (transition_done)
         since <= 6'h00;
      else if (since != 6'h3f)
         since <= since + 6'h01;
   end
   a_step_one: assert property ($changed(reference_code) |->
      reference_code == $past(reference_code) + 8'h01 || reference_code == $past(reference_code) - 8'h01)
      else $error("reference jumped");
   a_ref_quiet: assert property ($changed(reference_code) |-> transition_busy || transition_done)
      else $error("reference moved while idle");
   a_done_pulse: assert property (transition_done |=> !transition_done)
      else $error("done longer than one cycle");
   a_done_end: assert property ($fell(transition_busy) |-> transition_done)
      else $error("busy dropped without done");
   a_mask_busy: assert property (transition_busy || transition_done |-> supervision_masked)
      else $error("supervision live in transition");
   a_mask_len: assert property ($fell(supervision_masked) |-> since >= 6'h1e && since <= 6'h22)
      else $error("unmask delay wrong");
   a_trip_quiet: assert property (supervision_masked |-> !overvoltage_trip && !undervoltage_trip)
      else $error("trip while masked");
   a_pg_freeze: assert property (supervision_masked && $past(supervision_masked) |-> $stable(power_good_output))
      else $error("power good moved while masked");
   a_step_size: assert property ($past(nrst) && $stable(mode) |->
      step_uv == (mode == 2'h0 ? 16'h30d4 : 16'h61a8))
      else $error("step size wrong");
   // Main scenarios
   c_done: cover property ($fell(transition_busy));
   c_unmask: cover property ($fell(supervision_masked));
   c_coarse: cover property (transition_busy && mode != 2'h0);
endmodule // dvrs_props
bind dvrs_stepper dvrs_props i_props (.clk, .nrst, .mode, .reference_code, .step_uv, .transition_busy,
   .transition_done, .power_good_output, .overvoltage_trip, .undervoltage_trip, .supervision_masked);

// >>> dv/dvrs_vid_src.sv
`timescale 1ns/100ps
// Processor side driving the code lines
module dvrs_vid_src (
   // Clock
   input wire clk,
   // Code lines
   output reg [7:0] vid_code
);
   // Quiet lines until the bench asks
   initial begin
      vid_code = 8'h00;
   end
   // New code, then two full stepping periods of quiet
   task change(input [7:0] code, input integer per);
      begin
         vid_code = code;
         repeat (2 * per) @(negedge clk);
      end
   endtask
   // Blips under half a period; neighbours differ so a fall never confirms
   task blip(input [7:0] a, input [7:0] b, input [7:0] base, input integer per);
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            vid_code = i[0] ? a : b;
            repeat (per / 2 - 1) @(negedge clk);
            vid_code = base;
            @(negedge clk);
         end
      end
   endtask
endmodule // dvrs_vid_src

// >>> dv/dvrs_stepper_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the reference stepper
module dvrs_stepper_tb;
   reg clk, nrst, enable, soft_start_begin, power_good_raw, overvoltage_raw, undervoltage_raw;
   reg [1:0] mode;
   reg [15:0] sw_period, phase_sense_current;
   wire [7:0] vid_code, reference_code, offset_current;
   wire [15:0] step_uv, max_on_time;
   wire transition_busy, transition_done, power_good_output, overvoltage_trip;
   wire undervoltage_trip, supervision_masked, offset_current_on;
   integer failures, checks, cyc;
   dvrs_stepper i_dut (.clk, .nrst, .mode, .sw_period, .enable, .soft_start_begin, .vid_code, .power_good_raw,
      .overvoltage_raw, .undervoltage_raw, .phase_sense_current, .reference_code, .step_uv, .transition_busy,
      .transition_done, .power_good_output, .overvoltage_trip, .undervoltage_trip, .supervision_masked,
      .max_on_time, .offset_current_on, .offset_current);
   dvrs_vid_src i_cpu (.clk, .vid_code);
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Value compare
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks=%0d failures=%0d", checks, failures);
         if (failures == 0 && checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Bounded wait for done, adding elapsed cycles to cyc
   task wait_done;
      integer n;
      begin
         for (n = 0; n < 2000 && transition_done !== 1'b1; n = n + 1)
            @(negedge clk);
         cyc = cyc + n;
         if (n == 2000) begin
            failures = failures + 1;
            wrap_up;
         end
      end
   endtask
   // Offset source and on-time limit at both current ends
   task sc_misc;
      begin
         chk({15'h0000, offset_current_on}, 16'h0000);
         soft_start_begin = 1'b1;
         @(negedge clk);
         soft_start_begin = 1'b0;
         repeat (2) @(negedge clk);
         chk({7'h00, offset_current_on, offset_current}, 16'h0173);
         chk(max_on_time, 16'h0026);
         phase_sense_current = 16'h015e;
         repeat (3) @(negedge clk);
         chk(max_on_time, 16'h0013);
      end
   endtask
   // One multi-step change, supervision tripping in mid-transition
   task sc_change(input [1:0] m, input integer per, input [7:0] to, input integer n);
      begin
         mode = m;
         repeat (3) @(negedge clk);
         chk(step_uv, m == 2'h0 ? 16'h30d4 : 16'h61a8);
         cyc = 2 * per;
         i_cpu.change(to, per);
         {power_good_raw, overvoltage_raw, undervoltage_raw} = 3'h3;
         wait_done;
         chk({8'h00, reference_code}, {8'h00, to});
         chk({15'h0000, cyc >= n * per && cyc <= n * per + per + 4}, 16'h0001);
         repeat (28) @(negedge clk);
         chk({12'h000, supervision_masked, power_good_output, overvoltage_trip, undervoltage_trip}, 16'h000c);
         repeat (12) @(negedge clk);
         chk({12'h000, supervision_masked, power_good_output, overvoltage_trip, undervoltage_trip}, 16'h0003);
         {power_good_raw, overvoltage_raw, undervoltage_raw} = 3'h4;
         repeat (4) @(negedge clk);
      end
   endtask
   // A second code during a transition waits until the first ends
   task sc_ignore;
      begin
         i_cpu.change(8'h0b, 16);
         i_cpu.change(8'h08, 16);
         wait_done;
         chk({8'h00, reference_code}, 16'h000b);
         @(negedge clk);
         wait_done;
         chk({8'h00, reference_code}, 16'h0008);
         repeat (40) @(negedge clk);
      end
   endtask
   // Codes that vanish before the fall are never taken
   task sc_blip;
      begin
         i_cpu.blip(8'h20, 8'h21, 8'h08, 16);
         repeat (20) @(negedge clk);
         chk({7'h00, transition_busy, reference_code}, 16'h0008);
      end
   endtask
   // Reset values, then each scenario in turn
   initial begin
      failures = 0;
      checks = 0;
      {nrst, soft_start_begin, overvoltage_raw, undervoltage_raw} = 4'h0;
      {enable, power_good_raw} = 2'h3;
      mode = 2'h0;
      sw_period = 16'h0030;
      phase_sense_current = 16'h0000;
      repeat (12) @(negedge clk);
      chk({7'h00, transition_busy, reference_code}, 16'h0000);
      chk(step_uv, 16'h30d4);
      nrst = 1'b1;
      repeat (40) @(negedge clk);
      sc_misc;
      sc_change(2'h0, 16, 8'h05, 5);
      sc_change(2'h1, 48, 8'h02, 3);
      sc_change(2'h2, 48, 8'h06, 4);
      mode = 2'h0;
      sc_ignore;
      sc_blip;
      enable = 1'b0;
      repeat (3) @(negedge clk);
      chk({15'h0000, offset_current_on}, 16'h0000);
      wrap_up;
   end
endmodule // dvrs_stepper_tb
